// [core/ara_pkg.sv]
package ara_pkg;
  // register byte offsets (word aligned)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] RES_A_OFF = 8'h08;
  localparam logic [7:0] RES_B_OFF = 8'h0C;
  localparam logic [7:0] CMD_OFF = 8'h10;
  localparam logic [7:0] ROUTE_OFF = 8'h14;
  localparam logic [7:0] TEMP_OFF = 8'h18;
  // control register fields (one set per request, selected by write data bit 23)
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MASK_BIT = 1;
  localparam int CTRL_SHOT_BIT = 2;
  localparam int CTRL_IGN_BIT = 3;
  localparam int CTRL_BATT_BIT = 4;
  localparam int CTRL_COIN_BIT = 5;
  localparam int CTRL_DIV_BIT = 6;
  localparam int CTRL_SEL_LO_BIT = 7;
  localparam int CTRL_SEL_HI_BIT = 8;
  localparam int CTRL_PDONE_MSK_BIT = 9;
  localparam int CTRL_SDONE_MSK_BIT = 10;
  localparam int CTRL_EXT_BIT = 23;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  // status fields; done and removal flags clear by writing one
  localparam int STAT_PDONE_BIT = 0;
  localparam int STAT_SDONE_BIT = 1;
  localparam int STAT_BATT_IRQ_BIT = 2;
  localparam int STAT_SENSE_BIT = 3;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_OWNER_BIT = 5;
  // command fields
  localparam int CMD_START_BIT = 0;
  localparam int CMD_SEC_BIT = 1;
  // channel 7 routing codes
  localparam logic [1:0] SEL_LIGHT_A = 2'h0;
  localparam logic [1:0] SEL_DIE_TEMP = 2'h1;
  localparam logic [1:0] SEL_ID_LINE = 2'h2;
  localparam logic [1:0] SEL_LIGHT_B = 2'h3;
  // die temperature scale
  localparam logic [9:0] TEMP_CODE_25C = 10'h2A8;
  localparam int TEMP_UC_PER_LSB = 424400;
  // timing
  localparam int CLK_MHZ = 25;
  localparam int CONV_TIME_US = 8;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam int DEBOUNCE_TIME_US = 1000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {ARA_IDLE, ARA_CONV_P, ARA_CONV_S} ara_state_t;
endpackage

// [core/ara_result_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module ara_result_mem #(
  parameter int WIDTH = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem[0] <= '0;
      mem[1] <= '0;
    end else if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else if (ce) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// [core/ara_arbiter.sv]
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - removal check runs only while the removal-check enable is set
// - input above 31/32 of bias sets sense; debounced sense raises removal irq
// - coin-cell read enable routes channel 6 to coin cell at 2/3 scale
// - channel 7 source by 2-bit select; half-scale bit for light inputs
// - die temperature reads 680 at 25 C, about 0.4244 C per code
// - one converter shared by primary and secondary requests, kept apart
// - control write with bit 23 set goes to secondary request fields
// - bit 23 reads zero; secondary control fields never read back
// - primary and secondary results in two separate result registers
// - separate maskable done interrupts for primary and secondary
// - earlier-triggered request converts first
// - other-request hw trigger during conversion: mask 1 drops, 0 queues
// - trigger mask does not affect software starts
// - single-shot accepts only first hw trigger; host clears before rearming
// - two queued hw triggers: priority by mask (unmasked first), ties to primary
// - trigger-ignore drops every hw trigger pin transition
// - converter enable low drops hw and sw starts
module ara_arbiter
  import ara_pkg::*;
#(
  parameter int CONV_CNT = CONV_CYCLES,
  parameter int DEBOUNCE_CNT = DEBOUNCE_CYCLES,
  parameter int RES_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_trigger_pin,
  input wire logic batt_over_threshold,
  input wire logic [RES_W-1:0] core_result,
  output logic [2:0] core_channel,
  output logic core_start,
  output logic coin_cell_read_en,
  output logic [1:0] ch7_source_sel,
  output logic ch7_half_scale,
  output logic batt_removal_check_en,
  output logic batt_removal_sense,
  output logic batt_removal_irq,
  output logic primary_done_irq,
  output logic secondary_done_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // bus and control fields
  logic [10:0] ctrl_p;
  logic [10:0] ctrl_s;
  logic pdone;
  logic sdone;
  logic batt_flag;
  logic sense_meta;
  logic sense_pin;
  logic sense_sync;
  logic res_sel;
  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  logic pend_p;
  logic pend_s;
  logic hw_p;
  logic hw_s;
  logic shot_used_p;
  logic shot_used_s;
  logic [RES_W-1:0] res_rd;
  logic [15:0] conv_cnt;
  logic [24:0] deb_cnt;
  ara_state_t state;
  ara_state_t next_state;

  function automatic logic is_wr(input logic [7:0] off);
    return psel && penable && pready && pwrite && paddr == off;
  endfunction

  function automatic logic [1:0] sel_of(input logic [10:0] c);
    return {c[CTRL_SEL_HI_BIT], c[CTRL_SEL_LO_BIT]};
  endfunction

  wire logic acc = psel && penable;
  wire logic res_rd_req = psel && !pwrite && (paddr == RES_A_OFF || paddr == RES_B_OFF);
  wire logic enable = ctrl_p[CTRL_EN_BIT];
  wire logic start_cmd = is_wr(CMD_OFF) && pwdata[CMD_START_BIT];
  wire logic sw_p = start_cmd && !pwdata[CMD_SEC_BIT] && enable;
  wire logic sw_s = start_cmd && pwdata[CMD_SEC_BIT] && enable;
  wire logic trig_edge = trig_sync && !trig_prev;
  // global switches live in the primary set only
  wire logic trig_ok = trig_edge && enable && !ctrl_p[CTRL_IGN_BIT];
  wire logic busy = state != ARA_IDLE;
  wire logic fin = busy && conv_cnt == 16'(CONV_CNT - 1);
  // each request's hw trigger accepted when not blocked by its mask, its single shot or its own running conversion
  wire logic acc_hw_p = trig_ok && !(ctrl_p[CTRL_SHOT_BIT] && shot_used_p)
    && !(state == ARA_CONV_S && ctrl_p[CTRL_MASK_BIT]) && state != ARA_CONV_P;
  wire logic acc_hw_s = trig_ok && !(ctrl_s[CTRL_SHOT_BIT] && shot_used_s)
    && !(state == ARA_CONV_P && ctrl_s[CTRL_MASK_BIT]) && state != ARA_CONV_S;

  ////////////////////////////////////////////////////////////////////////////
  // control registers; bit 23 steers the write to the secondary set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_p <= CTRL_RESET;
      ctrl_s <= CTRL_RESET;
    end else if (ce && is_wr(CTRL_OFF)) begin
      if (pwdata[CTRL_EXT_BIT]) begin
        ctrl_s <= pwdata[10:0];
      end else begin
        ctrl_p <= pwdata[10:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      pready <= psel && !pready && !(res_rd_req && !res_sel);
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !pready && !pwrite) begin
        case (paddr)
          CTRL_OFF: prdata <= {21'h0, ctrl_p};
          STAT_OFF: prdata <= {26'h0, state == ARA_CONV_S, busy, sense_sync,
                               batt_flag, sdone, pdone};
          ROUTE_OFF: prdata <= {29'h0, ch7_half_scale, ch7_source_sel};
          TEMP_OFF: prdata <= {22'h0, TEMP_CODE_25C};
          RES_A_OFF, RES_B_OFF: prdata <= 32'(res_rd);
          default: pslverr <= 1'b1;
        endcase
      end
      if (acc && pready) begin
        pready <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger pin and sense synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
      sense_meta <= 1'b0;
      sense_sync <= 1'b0;
    end else if (ce) begin
      trig_meta <= hw_trigger_pin;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
      sense_meta <= batt_over_threshold;
      sense_pin <= sense_meta;
      // gate after the synchroniser so no logic sits ahead of the first flop
      sense_sync <= sense_pin && ctrl_p[CTRL_BATT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending requests and single-shot bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_p <= 1'b0;
      pend_s <= 1'b0;
      hw_p <= 1'b0;
      hw_s <= 1'b0;
      shot_used_p <= 1'b0;
      shot_used_s <= 1'b0;
    end else if (ce) begin
      if (next_state == ARA_CONV_P && state != ARA_CONV_P) begin
        pend_p <= 1'b0;
      end
      if (next_state == ARA_CONV_S && state != ARA_CONV_S) begin
        pend_s <= 1'b0;
      end
      if (sw_p || acc_hw_p) begin
        pend_p <= 1'b1;
        hw_p <= acc_hw_p && !sw_p;
      end
      if (sw_s || acc_hw_s) begin
        pend_s <= 1'b1;
        hw_s <= acc_hw_s && !sw_s;
      end
      if (!ctrl_p[CTRL_SHOT_BIT]) begin
        shot_used_p <= 1'b0;
      end else if (acc_hw_p) begin
        shot_used_p <= 1'b1;
      end
      if (!ctrl_s[CTRL_SHOT_BIT]) begin
        shot_used_s <= 1'b0;
      end else if (acc_hw_s) begin
        shot_used_s <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration: a request queued while idle starts at once, so order of arrival
  // decides; simultaneous hw triggers favour unmasked, then primary
  always_comb begin
    next_state = state;
    case (state)
      ARA_IDLE, ARA_CONV_P, ARA_CONV_S: begin
        if (state == ARA_IDLE || fin) begin
          next_state = ARA_IDLE;
          if (pend_p && pend_s && hw_p && hw_s &&
              ctrl_s[CTRL_MASK_BIT] < ctrl_p[CTRL_MASK_BIT]) begin
            next_state = ARA_CONV_S;
          end else if (pend_p) begin
            next_state = ARA_CONV_P;
          end else if (pend_s) begin
            next_state = ARA_CONV_S;
          end
        end
      end
      default: next_state = ARA_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ARA_IDLE;
      conv_cnt <= 16'h0000;
      core_start <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      core_start <= next_state != ARA_IDLE && (state == ARA_IDLE || fin);
      if (!busy || fin) begin
        conv_cnt <= 16'h0000;
      end else begin
        conv_cnt <= conv_cnt + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // done flags, write one to clear; a finishing conversion wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdone <= 1'b0;
      sdone <= 1'b0;
      primary_done_irq <= 1'b0;
      secondary_done_irq <= 1'b0;
    end else if (ce) begin
      if (fin && state == ARA_CONV_P) begin
        pdone <= 1'b1;
      end else if (is_wr(STAT_OFF) && pwdata[STAT_PDONE_BIT]) begin
        pdone <= 1'b0;
      end
      if (fin && state == ARA_CONV_S) begin
        sdone <= 1'b1;
      end else if (is_wr(STAT_OFF) && pwdata[STAT_SDONE_BIT]) begin
        sdone <= 1'b0;
      end
      primary_done_irq <= pdone && !ctrl_p[CTRL_PDONE_MSK_BIT];
      secondary_done_irq <= sdone && !ctrl_p[CTRL_SDONE_MSK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // battery removal debounce: sense must hold for the whole period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_cnt <= 25'h0000000;
      batt_flag <= 1'b0;
    end else if (ce) begin
      if (!sense_sync) begin
        deb_cnt <= 25'h0000000;
      end else if (deb_cnt != 25'(DEBOUNCE_CNT)) begin
        deb_cnt <= deb_cnt + 25'h0000001;
      end
      if (sense_sync && deb_cnt == 25'(DEBOUNCE_CNT - 1)) begin
        batt_flag <= 1'b1;
      end else if (is_wr(STAT_OFF) && pwdata[STAT_BATT_IRQ_BIT]) begin
        batt_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing outputs toward the analog front end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_channel <= 3'h0;
      coin_cell_read_en <= 1'b0;
      ch7_source_sel <= SEL_LIGHT_A;
      ch7_half_scale <= 1'b0;
      batt_removal_check_en <= 1'b0;
      batt_removal_sense <= 1'b0;
      batt_removal_irq <= 1'b0;
    end else if (ce) begin
      core_channel <= (next_state == ARA_CONV_S) ? 3'h7 : 3'h6;
      coin_cell_read_en <= ctrl_p[CTRL_COIN_BIT];
      ch7_source_sel <= sel_of(ctrl_p);
      // half scaling only means something for the two light inputs
      ch7_half_scale <= ctrl_p[CTRL_DIV_BIT] &&
        (sel_of(ctrl_p) == SEL_LIGHT_A || sel_of(ctrl_p) == SEL_LIGHT_B);
      batt_removal_check_en <= ctrl_p[CTRL_BATT_BIT];
      batt_removal_sense <= sense_sync;
      batt_removal_irq <= batt_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result store: one word per request, read back through the bus
  ara_result_mem #(.WIDTH(RES_W)) u_res (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_en(fin),
    .wr_addr(state == ARA_CONV_S),
    .wr_data(core_result),
    .rd_addr(paddr == RES_B_OFF),
    .rd_data(res_rd)
  );

  // result reads take one wait state: the memory's read register lags the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_sel <= 1'b0;
    end else if (ce) begin
      res_sel <= res_rd_req && !pready && !res_sel;
    end
  end

  a_sw_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state == ARA_IDLE && !pend_p && !pend_s && start_cmd && !enable)
      |=> !pend_p && !pend_s)
    else $error("start taken while disabled");
  a_ext_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && res_sel == 1'b0) |-> !prdata[CTRL_EXT_BIT])
    else $error("bit 23 read as one");
  a_fin_done: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && fin && state == ARA_CONV_P) |=> pdone)
    else $error("primary done not set");
  a_ign: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_p[CTRL_IGN_BIT] |-> !acc_hw_p && !acc_hw_s)
    else $error("trigger accepted while ignored");
  a_mask_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ARA_CONV_P && ctrl_s[CTRL_MASK_BIT]) |-> !acc_hw_s)
    else $error("masked trigger queued");
  a_shot: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_p[CTRL_SHOT_BIT] && shot_used_p) |-> !acc_hw_p)
    else $error("second single-shot trigger taken");
  a_deb: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(batt_flag) |-> $past(sense_sync))
    else $error("removal flag without sense");
  a_check_en: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_p[CTRL_BATT_BIT] [*3] |-> !sense_sync)
    else $error("sense while check disabled");
endmodule
`default_nettype wire

// [sim/ara_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ara_core_model #(
  parameter int CONV_CNT = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic core_start,
  input wire logic [9:0] next_result,
  output logic [9:0] core_result
);
  int cnt;
  logic [9:0] held;
  // value stands only while a conversion runs; scrambled when idle so a late sample shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      held <= 10'h000;
    end else if (core_start) begin
      cnt <= CONV_CNT + 2;
      held <= next_result;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      held <= ~held;
    end
  end
  assign core_result = held;
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ara_pkg::*;
  localparam int CV = 8;
  localparam int DB = 16;
  localparam logic [31:0] EN = 32'h1;
  localparam logic [31:0] EXT = 32'h800000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ce;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic hw, over, start, coin, half, bchk, sense, birq, pirq, sirq;
  logic [9:0] res, nres;
  logic [1:0] sel;
  logic [9:0] resq[$];
  int err_total, compares, starts, seed, i, s0;
  ara_arbiter #(.CONV_CNT(CV), .DEBOUNCE_CNT(DB)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_trigger_pin(hw), .batt_over_threshold(over),
    .core_result(res), .core_channel(), .core_start(start), .coin_cell_read_en(coin),
    .ch7_source_sel(sel), .ch7_half_scale(half), .batt_removal_check_en(bchk),
    .batt_removal_sense(sense), .batt_removal_irq(birq), .primary_done_irq(pirq),
    .secondary_done_irq(sirq));
  ara_core_model #(.CONV_CNT(CV)) core (.pclk(pclk), .presetn(presetn), .core_start(start),
    .next_result(nres), .core_result(res));
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (start === 1'h1) begin
      starts++;
      resq.push_back(nres);
    end
  end
  initial begin
    #2000000;
    err_total++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("errors %0d in %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk(32'(n < 20), 32'h1);
    if (n >= 20) give_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic pulse();
    hw <= 1'h1;
    cyc(3);
    hw <= 1'h0;
    cyc(3);
  endtask
  // wait for one of the three interrupt levels; an expired bound ends the run
  task automatic waitf(input int w, input int lim);
    int n;
    logic f;
    n = 0;
    f = 1'h0;
    while (f !== 1'h1 && n < lim) begin
      @(posedge pclk);
      n++;
      f = (w == 0) ? pirq : (w == 1) ? sirq : birq;
    end
    chk(32'(f === 1'h1), 32'h1);
    if (f !== 1'h1) give_verdict();
  endtask
  task automatic both_res(input logic [31:0] c);
    wr(CTRL_OFF, c);
    rd(RES_A_OFF);
    chk(q, {22'h0, resq[0]});
    rd(RES_B_OFF);
    chk(q, {22'h0, resq[1]});
    resq.delete();
    wr(STAT_OFF, 32'h7);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 54918;
    {err_total, compares, starts} = '0;
    {presetn, psel, penable, pwrite, hw, over} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nres = 10'h000;
    ce = 1'h1;
    cyc(8);
    presetn <= 1'h1;
    chk({start, pirq, sirq, birq, sense, bchk}, 32'h0);
    rd(CTRL_OFF);
    chk(q, 32'h0);
    rd(TEMP_OFF);
    chk(q, 32'h2A8);
    rd(8'h1C);
    chk(e, 32'h1);
    for (i = 0; i < 8; i++) begin
      // code 3 picks light input b; i steps the select through codes 0 to 3
      v = ($random(seed) & 32'h70) | (32'(i & 3) << 7);
      wr(CTRL_OFF, v);
      // routing outputs follow the control register one cycle later
      cyc(2);
      chk({sel, coin, bchk}, {v[8:7], v[5:4]});
      if (v[7] == v[8]) chk(half, v[6]);
      wr(CTRL_OFF, v | EXT | 32'h1FE);
      rd(CTRL_OFF);
      chk(q, v);
    end
    wr(CTRL_OFF, 32'h0);
    s0 = starts;
    wr(CMD_OFF, 32'h1);
    pulse();
    cyc(CV);
    chk(32'(starts), 32'(s0));
    nres <= 10'($random(seed));
    wr(CTRL_OFF, EN | 32'h2);
    wr(CMD_OFF, 32'h1);
    // clock enable low freezes the queued start
    ce <= 1'h0;
    cyc(CV + 4);
    chk(pirq, 32'h0);
    ce <= 1'h1;
    waitf(0, CV + 20);
    rd(STAT_OFF);
    chk({q[1:0], sirq}, 32'h2);
    wr(CTRL_OFF, 32'h2);
    rd(RES_A_OFF);
    chk(q, {22'h0, resq.pop_front()});
    wr(STAT_OFF, 32'h7);
    // other request unmasked: a hardware trigger mid-conversion is kept
    wr(CTRL_OFF, EXT);
    wr(CTRL_OFF, EN | 32'h2);
    wr(CMD_OFF, 32'h1);
    nres <= 10'($random(seed));
    cyc(1);
    pulse();
    nres <= 10'($random(seed));
    waitf(1, 3 * CV + 40);
    both_res(32'h2);
    wr(CTRL_OFF, EXT | 32'h2);
    wr(CTRL_OFF, EN | 32'h2);
    wr(CMD_OFF, 32'h1);
    cyc(1);
    pulse();
    cyc(2 * CV + 10);
    chk({pirq, sirq}, 32'h2);
    resq.delete();
    wr(STAT_OFF, 32'h7);
    wr(CTRL_OFF, EXT);
    wr(CTRL_OFF, EN | 32'h8);
    s0 = starts;
    pulse();
    cyc(CV);
    chk(32'(starts), 32'(s0));
    wr(CTRL_OFF, EXT | 32'h4);
    wr(CTRL_OFF, EN | 32'h4);
    s0 = starts;
    nres <= 10'($random(seed));
    pulse();
    nres <= 10'($random(seed));
    waitf(1, 3 * CV + 40);
    chk(32'(starts), 32'(s0 + 2));
    both_res(32'h4);
    wr(CTRL_OFF, EN | 32'h4);
    pulse();
    cyc(2 * CV + 10);
    chk(32'(starts), 32'(s0 + 2));
    wr(CTRL_OFF, EXT);
    wr(CTRL_OFF, EN);
    pulse();
    cyc(3 * CV + 20);
    chk(32'(starts), 32'(s0 + 4));
    resq.delete();
    wr(STAT_OFF, 32'h7);
    wr(CTRL_OFF, EN | 32'h200);
    wr(CMD_OFF, 32'h1);
    cyc(CV + 10);
    chk(pirq, 32'h0);
    wr(CMD_OFF, 32'h3);
    waitf(1, CV + 20);
    resq.delete();
    wr(STAT_OFF, 32'h7);
    wr(CTRL_OFF, 32'h10);
    over <= 1'h1;
    cyc(6);
    chk(sense, 32'h1);
    over <= 1'h0;
    cyc(4);
    chk(birq, 32'h0);
    over <= 1'h1;
    cyc(DB - 6);
    chk(birq, 32'h0);
    waitf(2, 20);
    over <= 1'h0;
    wr(CTRL_OFF, 32'h0);
    wr(STAT_OFF, 32'h7);
    over <= 1'h1;
    cyc(DB + 8);
    chk({sense, birq}, 32'h0);
    over <= 1'h0;
    give_verdict();
  end
endmodule
`default_nettype wire
